//--- verilog/bwt_map.vh
// Register offsets, field positions, reset values and timing counts of the bypass timer
`ifndef BWT_MAP_VH
`define BWT_MAP_VH

`define BWT_ADDR_W          8
`define BWT_DATA_W          8

`define BWT_ADDR_CFG        8'hF2
`define BWT_ADDR_SEG_MASK   8'hF3
`define BWT_ADDR_CTRL       8'hF4
`define BWT_ADDR_IRQ_STAT   8'hF5
`define BWT_ADDR_IRQ_MASK   8'hF6
`define BWT_ADDR_REMAIN     8'hF8

`define BWT_CFG_CODE_MSB    2
`define BWT_CFG_CODE_LSB    0
`define BWT_CFG_EXP_BIT     7
`define BWT_CTRL_MODE_BIT   0
`define BWT_IRQ_EXPIRE_BIT  0
`define BWT_IRQ_LATE_BIT    1
`define BWT_IRQ_W           2

`define BWT_RST_CODE        3'h0
`define BWT_RST_SEG_MASK    8'h00
`define BWT_RST_MODE        1'b0
`define BWT_RST_IRQ_MASK    2'h0

`define BWT_CLK_PERIOD_NS   5
`define BWT_TICK_PERIOD_NS  1000000000
`define BWT_TICK_CYCLES     (`BWT_TICK_PERIOD_NS / `BWT_CLK_PERIOD_NS)
`define BWT_MAX_SECONDS     64

`endif

//--- verilog/bwt_tick_gen.v
// One-second tick prescaler for the bypass timer
`timescale 1ns/10ps
module bwt_tick_gen #(
	parameter TICK_CYCLES = 200000000,
	parameter CNT_W       = 28
) (
	input  wire i_clk,
	input  wire i_rst,
	input  wire i_run,
	input  wire i_restart,
	output wire o_tick
);

	localparam integer     TICK_LAST_I = TICK_CYCLES - 1;
	localparam [CNT_W-1:0] TICK_LAST   = TICK_LAST_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CNT_ONE     = {{(CNT_W-1){1'b0}}, 1'b1};

	reg [CNT_W-1:0] cnt;

	assign o_tick = i_run && !i_restart && (cnt == TICK_LAST);

	// Restart aligns the second boundary to the write, so a reload gives a full period
	always @(posedge i_clk)
	begin
		if (i_rst || i_restart || !i_run)
			cnt <= {CNT_W{1'b0}};
		else if (cnt == TICK_LAST)
			cnt <= {CNT_W{1'b0}};
		else
			cnt <= cnt + CNT_ONE;
	end

endmodule

//--- verilog/bwt_timer.v
// Bypass watchdog timer: countdown, expiry flag, relay drive and register port
`timescale 1ns/10ps
`include "bwt_map.vh"
// What this block and its software must do
// [RULE1] Code zero expires; codes give 1..64 s; the code never expires a zero written while idle before the mode bit is set
// [RULE2] Timeout code field is write only
// [RULE3] Software rewrites nonzero code before expiry
// [RULE4] Expiry closes relays of masked segments
// [RULE5] Software rewrites within half the period
// [RULE6] Every code write reloads the countdown; the code ignores a write in the running cycle after the mode bit drops
// [RULE7] Bits three to six do nothing
// [RULE8] Top bit reads expired, clears leaving mode
// [RULE9] Each mask bit selects one segment
// [RULE10] Prescaled one-second tick; reset clears flag
module bwt_timer #(
	parameter NUM_SEG     = 2,
	parameter TICK_CYCLES = `BWT_TICK_CYCLES,
	parameter TICK_CNT_W  = 28
) (
	input  wire                    i_clk,
	input  wire                    i_rst,
	input  wire [`BWT_ADDR_W-1:0]  i_addr,
	input  wire [`BWT_DATA_W-1:0]  i_wdata,
	input  wire                    i_wr,
	input  wire                    i_rd,
	output reg  [`BWT_DATA_W-1:0]  o_rdata,
	output reg  [NUM_SEG-1:0]      o_relay_close,
	output wire                    o_expired,
	output wire                    o_irq
);

	localparam ST_IDLE    = 3'b001;
	localparam ST_RUN     = 3'b010;
	localparam ST_EXPIRED = 3'b100;

	localparam [6:0] CNT_ZERO = 7'h00;
	localparam [6:0] CNT_ONE  = 7'h01;
	localparam [7:0] SEG_RST  = `BWT_RST_SEG_MASK;

	// Seconds selected by a code: zero, then powers of two up to the maximum
	function [6:0] bwt_period;
		input [2:0] code;
		begin
			if (code == 3'h0)
				bwt_period = CNT_ZERO;
			else
				bwt_period = CNT_ONE << (code - 3'h1);
		end
	endfunction

	reg [2:0]                state;
	reg [2:0]                next_state;
	reg [6:0]                count;
	reg [6:0]                next_count;
	reg [NUM_SEG-1:0]        seg_mask;
	reg                      mode;
	reg [`BWT_IRQ_W-1:0]     irq_stat;
	reg [`BWT_IRQ_W-1:0]     irq_mask;
	reg [`BWT_IRQ_W-1:0]     next_irq_stat;
	reg [`BWT_DATA_W-1:0]    next_rdata;
	reg                      expire_evt;

	wire cfg_wr  = i_wr && (i_addr == `BWT_ADDR_CFG);
	wire mask_wr = i_wr && (i_addr == `BWT_ADDR_SEG_MASK);
	wire ctrl_wr = i_wr && (i_addr == `BWT_ADDR_CTRL);
	wire imsk_wr = i_wr && (i_addr == `BWT_ADDR_IRQ_MASK);
	wire stat_rd = i_rd && (i_addr == `BWT_ADDR_IRQ_STAT);
	wire tick;

	bwt_tick_gen #(
		.TICK_CYCLES (TICK_CYCLES),
		.CNT_W       (TICK_CNT_W)
	) u_tick (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_run     (state == ST_RUN),
		.i_restart (cfg_wr),
		.o_tick    (tick)                                   // [RULE10]
	);

	assign o_expired = (state == ST_EXPIRED);
	assign o_irq     = |(irq_stat & irq_mask);

	// Countdown state machine
	always @*
	begin
		next_state = state;
		next_count = count;
		expire_evt = 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (cfg_wr)
				begin
					next_count = bwt_period(i_wdata[`BWT_CFG_CODE_MSB:`BWT_CFG_CODE_LSB]); // [RULE6]
					if (mode)
						next_state = ST_RUN;
				end
				else if (mode && (count != CNT_ZERO))
					next_state = ST_RUN;
			end
			ST_RUN:
			begin
				if (!mode)
					next_state = ST_IDLE;
				else if (cfg_wr)
					next_count = bwt_period(i_wdata[`BWT_CFG_CODE_MSB:`BWT_CFG_CODE_LSB]); // [RULE6]
				else if (count == CNT_ZERO)
				begin
					next_state = ST_EXPIRED;                     // [RULE1]
					expire_evt = 1'b1;
				end
				else if (tick)
					next_count = count - CNT_ONE;                // [RULE10]
			end
			ST_EXPIRED:
			begin
				// A late rewrite reloads the count but cannot undo the bypass
				if (!mode)
					next_state = ST_IDLE;                        // [RULE8]
				if (cfg_wr)
					next_count = bwt_period(i_wdata[`BWT_CFG_CODE_MSB:`BWT_CFG_CODE_LSB]); // [RULE6]
			end
			default:
			begin
				next_state = ST_IDLE;
				next_count = CNT_ZERO;
			end
		endcase
	end

	// A nonzero code written while idle only arms the timer; counting starts in timer mode
	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state <= ST_IDLE;                                    // [RULE10]
			count <= CNT_ZERO;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
		end
	end

	// Configuration registers; the code is not kept, it only reloads the countdown
	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			seg_mask <= SEG_RST[NUM_SEG-1:0];
			mode     <= `BWT_RST_MODE;
			irq_mask <= `BWT_RST_IRQ_MASK;
		end
		else
		begin
			if (mask_wr)
				seg_mask <= i_wdata[NUM_SEG-1:0];                // [RULE9]
			if (ctrl_wr)
				mode <= i_wdata[`BWT_CTRL_MODE_BIT];
			if (imsk_wr)
				irq_mask <= i_wdata[`BWT_IRQ_W-1:0];
		end
	end

	// Relays only ever close on expiry; released when timer mode is left
	always @(posedge i_clk)
	begin
		if (i_rst)
			o_relay_close <= {NUM_SEG{1'b0}};
		else if (state == ST_IDLE)
			o_relay_close <= {NUM_SEG{1'b0}};
		else if (expire_evt)
			o_relay_close <= o_relay_close | seg_mask;           // [RULE4] [RULE9]
	end

	// Sticky events; a set in the clearing cycle survives the read
	always @*
	begin
		next_irq_stat = irq_stat;
		if (stat_rd)
			next_irq_stat = {`BWT_IRQ_W{1'b0}};
		if (expire_evt)
			next_irq_stat[`BWT_IRQ_EXPIRE_BIT] = 1'b1;
		if (cfg_wr && (state == ST_EXPIRED))
			next_irq_stat[`BWT_IRQ_LATE_BIT] = 1'b1;
	end

	always @(posedge i_clk)
	begin
		if (i_rst)
			irq_stat <= {`BWT_IRQ_W{1'b0}};
		else
			irq_stat <= next_irq_stat;
	end

	// Read mux; write-only and unused bits read as zero
	always @*
	begin
		next_rdata = {`BWT_DATA_W{1'b0}};
		if (i_rd)
		begin
			case (i_addr)
				`BWT_ADDR_CFG:
					next_rdata[`BWT_CFG_EXP_BIT] = o_expired;    // [RULE2] [RULE7] [RULE8]
				`BWT_ADDR_SEG_MASK:
					next_rdata[NUM_SEG-1:0] = seg_mask;
				`BWT_ADDR_CTRL:
					next_rdata[`BWT_CTRL_MODE_BIT] = mode;
				`BWT_ADDR_IRQ_STAT:
					next_rdata[`BWT_IRQ_W-1:0] = irq_stat;
				`BWT_ADDR_IRQ_MASK:
					next_rdata[`BWT_IRQ_W-1:0] = irq_mask;
				`BWT_ADDR_REMAIN:
					next_rdata[6:0] = count;
				default:
					next_rdata = {`BWT_DATA_W{1'b0}};
			endcase
		end
	end

	// Read data stand for exactly one cycle after the strobe
	always @(posedge i_clk)
	begin
		if (i_rst)
			o_rdata <= {`BWT_DATA_W{1'b0}};
		else
			o_rdata <= next_rdata;
	end

endmodule

//--- testbench/bwt_timer_asserts.sv
// Port assertions for the bypass timer
`timescale 1ns/10ps
module bwt_timer_asserts (
	input wire       i_clk,
	input wire       i_rst,
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire       i_wr,
	input wire       i_rd,
	input wire [7:0] o_rdata,
	input wire [1:0] o_relay_close,
	input wire       o_expired,
	input wire       o_irq
);
	reg       mode;
	reg [1:0] seg;
	wire      rd_cfg = i_rd && i_addr == 8'hf2;
	wire      wr_cfg = i_wr && i_addr == 8'hf2 && mode && !o_expired;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Shadows of mode and mask, which the ports do not show
	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			mode <= 1'b0;
			seg  <= 2'h0;
		end
		else
		begin
			if (i_wr && i_addr == 8'hf4)
				mode <= i_wdata[0];
			if (i_wr && i_addr == 8'hf3)
				seg <= i_wdata[1:0];
		end
	end
	rd_flag_a: assert property (rd_cfg |=> o_rdata[7] == $past(o_expired))
		else $error("flag");
	rd_unused_a: assert property (rd_cfg |=> o_rdata[6:0] == 7'h00)
		else $error("unused");
	code_zero_a: assert property (wr_cfg && i_wdata[2:0] == 3'h0 |-> ##2 o_expired)
		else $error("code 0");
	code_one_a: assert property (wr_cfg && i_wdata[2:0] == 3'h1 |=>
		!o_expired [*8] ##[1:6] o_expired) else $error("code 1");
	// The state leaves expiry one cycle after the mode bit drops
	mode_off_a: assert property (!mode && !$past(mode) |-> !o_expired)
		else $error("mode");
	relay_mask_a: assert property ($rose(o_expired) |-> ##[0:1] o_relay_close == seg)
		else $error("mask");
	relay_idle_a: assert property (!o_expired && $past(!o_expired) |->
		o_relay_close == 2'h0) else $error("idle");
	reset_clr_a: assert property (disable iff (1'b0) i_rst |=>
		!o_expired && o_relay_close == 2'h0 && !o_irq) else $error("reset");
endmodule
bind bwt_timer bwt_timer_asserts i_bwt_timer_asserts (.i_clk(i_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_relay_close(o_relay_close), .o_expired(o_expired), .o_irq(o_irq));

//--- testbench/bwt_relay_model.sv
// Relay driver model of the bypass segments
`timescale 1ns/10ps
module bwt_relay_model (
	input  wire       i_clk,
	input  wire [1:0] i_close,
	output reg  [1:0] o_closed
);
	// Each relay follows its own drive one clock later
	always @(posedge i_clk)
		o_closed <= i_close;
endmodule

//--- testbench/tb.sv
// Self-checking bench for the bypass watchdog timer
`timescale 1ns/10ps
module tb;
	localparam T = 10;
	reg        i_clk = 1'b0;
	reg        i_rst = 1'b1;
	reg        i_wr = 1'b0;
	reg        i_rd = 1'b0;
	reg  [7:0] i_addr = 8'h00;
	reg  [7:0] i_wdata = 8'h00;
	wire [7:0] o_rdata;
	wire [1:0] o_relay_close;
	wire [1:0] relays;
	wire       o_expired;
	wire       o_irq;
	integer    n_errors = 0;
	integer    check_count = 0;
	integer    cyc = 0;
	integer    c, n, e;
	always #2.5 i_clk = ~i_clk;
	bwt_timer #(.TICK_CYCLES(T)) i_bwt_timer (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_relay_close(o_relay_close), .o_expired(o_expired), .o_irq(o_irq));
	bwt_relay_model i_bwt_relay_model (.i_clk(i_clk), .i_close(o_relay_close), .o_closed(relays));
	task chk(input [7:0] seen, input [7:0] exp, input [63:0] nm);
	begin
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			n_errors = n_errors + 1;
			$display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] v);
	begin
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	end
	endtask
	task rd(input [7:0] a, input [7:0] exp);
	begin
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp, "rdata");
	end
	endtask
	task wrap_up;
	begin
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	always @(posedge i_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			n_errors = n_errors + 1;
			wrap_up;
		end
	end
	initial
	begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(8'hf2, 8'h00);
		rd(8'hf4, 8'h00);
		rd(8'hf9, 8'h00);
		$display("test reset done");
		for (c = 0; c < 8; c = c + 1)
		begin
			e = c ? T << (c - 1) : 0;
			wr(8'hf3, 8'(c % 3 + 1));
			wr(8'hf6, 8'(c % 2));
			rd(8'hf3, 8'(c % 3 + 1));
			rd(8'hf6, 8'(c % 2));
			// Long code first, so the second write must reload the countdown
			wr(8'hf2, 8'h07);
			wr(8'hf4, 8'h01);
			repeat (30) @(posedge i_clk);
			wr(8'hf2, 8'h78 | 8'(c));
			n = 0;
			while (o_expired !== 1'b1 && n < 700)
			begin
				@(posedge i_clk);
				#1;
				n = n + 1;
			end
			chk(8'(n >= e && n <= e + 3), 8'h01, "elapsed");
			rd(8'hf2, 8'h80);
			chk(8'(relays), 8'(c % 3 + 1), "relays");
			chk(8'(o_irq), 8'(c % 2), "irq");
			wr(8'hf2, 8'(c));
			chk(8'(o_expired), 8'h01, "expired");
			rd(8'hf8, 8'(c ? 1 << (c - 1) : 0));
			rd(8'hf5, 8'h03);
			chk(8'(o_irq), 8'h00, "irq");
			rd(8'hf5, 8'h00);
			wr(8'hf4, 8'h00);
			rd(8'hf2, 8'h00);
			// Drive drops two edges after the mode write, the relay one edge later
			@(posedge i_clk);
			#1;
			chk(8'(relays), 8'h00, "relays");
			$display("test code %0d done", c);
		end
		wrap_up;
	end
endmodule
